// ===== design/pcm_port.sv
// Decided for this implementation: the AXI4-Lite interface to the registers and the placing of the registers.
`timescale 1ns/10ps
module pcm_port (
    input  wire logic                        aclk,
    input  wire logic                        aresetn,
    input  wire pcm_port_pkg::axil_req_type  axil_req,
    output pcm_port_pkg::axil_rsp_type       axil_rsp,
    input  wire logic                        pclk,
    input  wire logic                        frame_sync_pulse,
    input  wire logic                        pcm_rx_in,
    output logic                             pcm_tx_out,
    output logic                             pcm_tx_oe
);
    import pcm_port_pkg::*;

    typedef struct packed {
        axil_rsp_type      rsp;
        logic              aw_held;
        logic              w_held;
        logic [AXI_AW-1:0] awaddr;
        logic [31:0]       wdata;
        logic [3:0]        wstrb;
        logic [31:0]       ctrl;
        logic [31:0]       slot;
        logic [31:0]       txd;
        logic [31:0]       rxd;
        logic              rx_new;
        logic              rx_ovr;
        logic              upd_tgl;
        logic              rxt_s1;
        logic              rxt_s2;
        logic              rxt_s3;
        logic              run_s1;
        logic              run_s2;
    } a_state_type;

    typedef struct packed {
        logic             upd_s1;
        logic             upd_s2;
        logic             upd_s3;
        cfg_type          cfg;
        logic [31:0]      tx_word;
        link_state_type   state;
        logic             fs_d;
        logic [CNT_W-1:0] bit_cnt;
        logic [CNT_W-1:0] frame_len;
        logic             tx_en;
        logic             tx_bit;
        logic [15:0]      rx_sh;
        logic [31:0]      rx_word;
        logic             rx_tgl;
    } p_state_type;

    a_state_type      a_r;
    a_state_type      a_nxt;
    p_state_type      p_r;
    p_state_type      p_nxt;
    logic [1:0]       prst_sync_r;
    logic             prst_n;
    logic [1:0]       fall_r;
    cfg_type          a_cfg;
    logic             fs_rise;
    logic [CNT_W-1:0] tx_start;
    logic [CNT_W-1:0] rx_start;
    logic [CNT_W-1:0] len;
    logic [CNT_W-1:0] half;
    win_type          tw;
    win_type          rw;
    logic             rx_ev;

    // Locates a count inside the first or the wideband second slot set
    function automatic win_type win_at(input logic [CNT_W-1:0] cnt,
                                       input logic [CNT_W-1:0] start,
                                       input logic [CNT_W-1:0] wlen,
                                       input logic [CNT_W-1:0] whalf,
                                       input logic             wide);
        logic [CNT_W-1:0] off1;
        logic [CNT_W-1:0] off2;
        logic [CNT_W-1:0] pos;
        win_at = '0;
        off1   = cnt - start;
        off2   = cnt - start - whalf;
        pos    = '0;
        if (cnt >= start && off1 < wlen) begin
            win_at.hit = 1'b1;
            pos        = wlen - off1 - CNT_W'(1);
        end else if (wide && cnt >= start + whalf && off2 < wlen) begin
            win_at.hit    = 1'b1;
            win_at.second = 1'b1;
            pos           = wlen - off2 - CNT_W'(1);
        end
        win_at.idx = pos[3:0];
    endfunction

    function automatic logic [31:0] merge(input logic [31:0] old_v,
                                          input logic [31:0] new_v,
                                          input logic [3:0]  strb);
        merge = old_v;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                merge[i*8 +: 8] = new_v[i*8 +: 8];
            end
        end
    endfunction

    // Configuration and sample words only change on a write, which also
    // flips upd_tgl; the link side copies them after seeing that toggle.
    always_comb begin
        a_cfg         = '0;
        a_cfg.enable  = a_r.ctrl[CTRL_EN_BIT];
        a_cfg.wide    = a_r.ctrl[CTRL_WIDE_BIT];
        a_cfg.linear  = a_r.ctrl[CTRL_LIN_BIT];
        a_cfg.tx_fall = a_r.ctrl[CTRL_FALL_BIT];
        a_cfg.tx_cs   = a_r.ctrl[CTRL_TXCS_LSB +: CS_W];
        a_cfg.rx_cs   = a_r.ctrl[CTRL_RXCS_LSB +: CS_W];
        a_cfg.tx_ts   = a_r.slot[SLOT_TX_LSB +: TS_W];
        a_cfg.rx_ts   = a_r.slot[SLOT_RX_LSB +: TS_W];
    end

    assign rx_ev = a_r.rxt_s2 ^ a_r.rxt_s3;

    always_comb begin
        logic [31:0] wv;
        wv    = merge(32'h00000000, a_r.wdata, a_r.wstrb);
        a_nxt = a_r;
        a_nxt.rxt_s1 = p_r.rx_tgl;
        a_nxt.rxt_s2 = a_r.rxt_s1;
        a_nxt.rxt_s3 = a_r.rxt_s2;
        a_nxt.run_s1 = (p_r.state == LINK_RUN);
        a_nxt.run_s2 = a_r.run_s1;
        if (axil_req.awvalid && a_r.rsp.awready) begin
            a_nxt.awaddr      = axil_req.awaddr;
            a_nxt.aw_held     = 1'b1;
            a_nxt.rsp.awready = 1'b0;
        end
        if (axil_req.wvalid && a_r.rsp.wready) begin
            a_nxt.wdata      = axil_req.wdata;
            a_nxt.wstrb      = axil_req.wstrb;
            a_nxt.w_held     = 1'b1;
            a_nxt.rsp.wready = 1'b0;
        end
        if (a_r.aw_held && a_r.w_held && !a_r.rsp.bvalid) begin
            a_nxt.rsp.bvalid = 1'b1;
            a_nxt.rsp.bresp  = RESP_OKAY;
            case (a_r.awaddr)
                CTRL_OFS: begin
                    a_nxt.ctrl    = merge(a_r.ctrl, a_r.wdata, a_r.wstrb) & CTRL_MASK;
                    a_nxt.upd_tgl = ~a_r.upd_tgl;
                end
                SLOT_OFS: begin
                    a_nxt.slot    = merge(a_r.slot, a_r.wdata, a_r.wstrb) & SLOT_MASK;
                    a_nxt.upd_tgl = ~a_r.upd_tgl;
                end
                TXD_OFS: begin
                    a_nxt.txd     = merge(a_r.txd, a_r.wdata, a_r.wstrb);
                    a_nxt.upd_tgl = ~a_r.upd_tgl;
                end
                STAT_OFS: begin
                    if (wv[STAT_OVR_BIT]) begin
                        a_nxt.rx_ovr = 1'b0;
                    end
                end
                RXD_OFS: ;
                default: begin
                    a_nxt.rsp.bresp = RESP_SLVERR;
                end
            endcase
        end
        if (a_r.rsp.bvalid && axil_req.bready) begin
            a_nxt.rsp.bvalid  = 1'b0;
            a_nxt.aw_held     = 1'b0;
            a_nxt.w_held      = 1'b0;
            a_nxt.rsp.awready = 1'b1;
            a_nxt.rsp.wready  = 1'b1;
        end
        if (axil_req.arvalid && a_r.rsp.arready) begin
            a_nxt.rsp.arready = 1'b0;
            a_nxt.rsp.rvalid  = 1'b1;
            a_nxt.rsp.rresp   = RESP_OKAY;
            a_nxt.rsp.rdata   = 32'h00000000;
            case (axil_req.araddr)
                CTRL_OFS: a_nxt.rsp.rdata = a_r.ctrl;
                SLOT_OFS: a_nxt.rsp.rdata = a_r.slot;
                TXD_OFS:  a_nxt.rsp.rdata = a_r.txd;
                RXD_OFS: begin
                    a_nxt.rsp.rdata = a_r.rxd;
                    a_nxt.rx_new    = 1'b0;
                end
                STAT_OFS: begin
                    a_nxt.rsp.rdata[STAT_RXNEW_BIT] = a_r.rx_new;
                    a_nxt.rsp.rdata[STAT_OVR_BIT]   = a_r.rx_ovr;
                    a_nxt.rsp.rdata[STAT_RUN_BIT]   = a_r.run_s2;
                end
                default: a_nxt.rsp.rresp = RESP_SLVERR;
            endcase
        end
        if (a_r.rsp.rvalid && axil_req.rready) begin
            a_nxt.rsp.rvalid  = 1'b0;
            a_nxt.rsp.arready = 1'b1;
        end
        // Arrival placed last so a new sample wins over a same-cycle clear
        if (rx_ev) begin
            a_nxt.rxd    = p_r.rx_word;
            a_nxt.rx_new = 1'b1;
            if (a_r.rx_new) begin
                a_nxt.rx_ovr = 1'b1;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            a_r             <= '0;
            a_r.ctrl        <= CTRL_RST;
            a_r.slot        <= SLOT_RST;
            a_r.txd         <= TXD_RST;
            a_r.rsp.awready <= 1'b1;
            a_r.rsp.wready  <= 1'b1;
            a_r.rsp.arready <= 1'b1;
        end else begin
            a_r <= a_nxt;
        end
    end

    assign axil_rsp = a_r.rsp;

    // Link-side reset follows the bus reset through two flops
    always_ff @(posedge pclk) begin
        prst_sync_r <= {prst_sync_r[0], aresetn};
    end
    assign prst_n = prst_sync_r[1];

    assign fs_rise  = frame_sync_pulse && !p_r.fs_d;
    assign len      = p_r.cfg.linear ? LEN_LIN : LEN_COMP;
    assign half     = {1'b0, p_r.frame_len[CNT_W-1:1]};
    assign tx_start = CNT_W'({p_r.cfg.tx_ts, 3'h0}) + CNT_W'(p_r.cfg.tx_cs);
    assign rx_start = CNT_W'({p_r.cfg.rx_ts, 3'h0}) + CNT_W'(p_r.cfg.rx_cs);
    assign rw       = win_at(p_r.bit_cnt, rx_start, len, half, p_r.cfg.wide);

    always_comb begin
        logic [15:0] got;
        p_nxt        = p_r;
        got          = {p_r.rx_sh[14:0], pcm_rx_in};
        p_nxt.upd_s1 = a_r.upd_tgl;
        p_nxt.upd_s2 = p_r.upd_s1;
        p_nxt.upd_s3 = p_r.upd_s2;
        if (p_r.upd_s2 ^ p_r.upd_s3) begin
            p_nxt.cfg     = a_cfg;
            p_nxt.tx_word = a_r.txd;
        end
        p_nxt.fs_d = frame_sync_pulse;
        case (p_r.state)
            LINK_IDLE: begin
                if (fs_rise) begin
                    p_nxt.state   = LINK_RUN;
                    p_nxt.bit_cnt = '0;
                end
            end
            LINK_RUN: begin
                if (fs_rise) begin
                    p_nxt.bit_cnt   = '0;
                    p_nxt.frame_len = p_r.bit_cnt + CNT_W'(1);
                end else if (p_r.bit_cnt != '1) begin
                    p_nxt.bit_cnt = p_r.bit_cnt + CNT_W'(1);
                end
            end
            default: p_nxt.state = LINK_IDLE;
        endcase
        // Taken one bit clock after launch; the last frame bit lands on the sync edge
        if (p_r.state == LINK_RUN && p_r.cfg.enable && rw.hit) begin
            p_nxt.rx_sh = got;
            if (rw.idx == 4'h0) begin
                if (rw.second) begin
                    p_nxt.rx_word[31:16] = p_r.cfg.linear ? got : {8'h00, got[7:0]};
                end else begin
                    p_nxt.rx_word[15:0] = p_r.cfg.linear ? got : {8'h00, got[7:0]};
                end
                if (!p_r.cfg.wide || rw.second) begin
                    p_nxt.rx_tgl = ~p_r.rx_tgl;
                end
            end
        end
        tw           = win_at(p_nxt.bit_cnt, tx_start, len, half, p_r.cfg.wide);
        p_nxt.tx_en  = (p_nxt.state == LINK_RUN) && p_r.cfg.enable && tw.hit
                       && (p_r.tx_en || CNT_W'(tw.idx) == len - CNT_W'(1));
        p_nxt.tx_bit = 1'b0;
        if (tw.hit) begin
            p_nxt.tx_bit = tw.second ? p_r.tx_word[16 + tw.idx] : p_r.tx_word[tw.idx];
        end
    end

    always_ff @(posedge pclk) begin
        if (!prst_n) begin
            p_r <= '0;
        end else begin
            p_r <= p_nxt;
        end
    end

    // Half a bit clock later for falling-edge launch
    always_ff @(negedge pclk) begin
        if (!prst_n) begin
            fall_r <= 2'h0;
        end else begin
            fall_r <= {p_r.tx_en, p_r.tx_bit};
        end
    end

    assign pcm_tx_out = p_r.cfg.tx_fall ? fall_r[0] : p_r.tx_bit;
    assign pcm_tx_oe  = p_r.cfg.tx_fall ? fall_r[1] : p_r.tx_en;

    a_frame_restart: assert property (@(posedge pclk) disable iff (!prst_n)
        fs_rise |=> p_r.bit_cnt == '0)
        else $error("bit count not restarted by frame sync");
    a_bit_step: assert property (@(posedge pclk) disable iff (!prst_n)
        (p_r.state == LINK_RUN && !fs_rise && p_r.bit_cnt != '1)
        |=> p_r.bit_cnt == $past(p_r.bit_cnt) + CNT_W'(1))
        else $error("bit count did not advance one per bit clock");
    a_byte_len: assert property (@(posedge pclk) disable iff (!prst_n || !p_r.cfg.enable)
        $rose(p_r.tx_en) |-> p_r.tx_en [*8])
        else $error("transmit slot shorter than one byte");
    a_slot_start: assert property (@(posedge pclk) disable iff (!prst_n)
        ($rose(p_r.tx_en) && !p_r.cfg.wide && $stable(p_r.cfg))
        |-> p_r.bit_cnt == tx_start)
        else $error("transmit slot started at wrong bit");
    a_msb_first: assert property (@(posedge pclk) disable iff (!prst_n)
        ($rose(p_r.tx_en) && p_r.bit_cnt == tx_start && $stable(p_r.tx_word))
        |-> p_r.tx_bit == (p_r.cfg.linear ? p_r.tx_word[15] : p_r.tx_word[7]))
        else $error("first transmitted bit is not the msb");
    a_release_off: assert property (@(posedge pclk) disable iff (!prst_n)
        !p_r.cfg.enable |=> !p_r.tx_en)
        else $error("transmit driven while port disabled");
    a_rx_flag: assert property (@(posedge aclk) disable iff (!aresetn)
        rx_ev |=> a_r.rx_new && a_r.rxd == $past(p_r.rx_word))
        else $error("received sample not presented to software");
    a_bresp_hold: assert property (@(posedge aclk) disable iff (!aresetn)
        (axil_rsp.bvalid && !axil_req.bready) |=> axil_rsp.bvalid && $stable(axil_rsp.bresp))
        else $error("write response dropped before bready");
    a_read_answer: assert property (@(posedge aclk) disable iff (!aresetn)
        (axil_req.arvalid && axil_rsp.arready) |=> axil_rsp.rvalid && !axil_rsp.arready)
        else $error("read not answered in one cycle");

    c_rx_sample: cover property (@(posedge aclk) disable iff (!aresetn) rx_ev);
    c_wide_set: cover property (@(posedge pclk) disable iff (!prst_n)
        p_r.cfg.wide && p_r.tx_en && p_r.bit_cnt >= tx_start + half);
    c_linear_tx: cover property (@(posedge pclk) disable iff (!prst_n)
        p_r.cfg.linear && $fell(p_r.tx_en));
    c_axi_write: cover property (@(posedge aclk) disable iff (!aresetn)
        axil_rsp.bvalid && axil_req.bready);

endmodule // pcm_port

// ===== design/pcm_port_pkg.sv
package pcm_port_pkg;

    // Register bus
    localparam int          AXI_AW      = 8;
    localparam logic [7:0]  CTRL_OFS    = 8'h00;
    localparam logic [7:0]  SLOT_OFS    = 8'h04;
    localparam logic [7:0]  TXD_OFS     = 8'h08;
    localparam logic [7:0]  RXD_OFS     = 8'h0C;
    localparam logic [7:0]  STAT_OFS    = 8'h10;
    localparam logic [1:0]  RESP_OKAY   = 2'h0;
    localparam logic [1:0]  RESP_SLVERR = 2'h2;

    // Control register fields
    localparam int          CTRL_EN_BIT    = 0;
    localparam int          CTRL_WIDE_BIT  = 1;
    localparam int          CTRL_LIN_BIT   = 2;
    localparam int          CTRL_FALL_BIT  = 3;
    localparam int          CTRL_TXCS_LSB  = 4;
    localparam int          CTRL_RXCS_LSB  = 8;
    localparam logic [31:0] CTRL_MASK      = 32'h0000077F;
    localparam logic [31:0] CTRL_RST       = 32'h00000000;

    // Slot register fields
    localparam int          SLOT_TX_LSB    = 0;
    localparam int          SLOT_RX_LSB    = 8;
    localparam logic [31:0] SLOT_MASK      = 32'h00007F7F;
    localparam logic [31:0] SLOT_RST       = 32'h00000000;
    localparam logic [31:0] TXD_RST        = 32'h00000000;

    // Status register fields
    localparam int          STAT_RXNEW_BIT = 0;
    localparam int          STAT_OVR_BIT   = 1;
    localparam int          STAT_RUN_BIT   = 2;

    // Highway geometry
    localparam int          FRAME_HZ     = 8000;
    localparam int          PCLK_MIN_HZ  = 1024000;
    localparam int          PCLK_MAX_HZ  = 8192000;
    localparam int          BITS_MAX     = PCLK_MAX_HZ / FRAME_HZ;
    localparam int          CNT_W        = $clog2(BITS_MAX) + 1;
    localparam int          TS_W         = 7;
    localparam int          CS_W         = 3;
    localparam logic [CNT_W-1:0] LEN_COMP = CNT_W'(8);
    localparam logic [CNT_W-1:0] LEN_LIN  = CNT_W'(16);

    typedef enum logic [0:0] {
        LINK_IDLE = 1'b0,
        LINK_RUN  = 1'b1
    } link_state_type;

    typedef struct packed {
        logic            enable;
        logic            wide;
        logic            linear;
        logic            tx_fall;
        logic [CS_W-1:0] tx_cs;
        logic [CS_W-1:0] rx_cs;
        logic [TS_W-1:0] tx_ts;
        logic [TS_W-1:0] rx_ts;
    } cfg_type;

    typedef struct packed {
        logic       hit;
        logic       second;
        logic [3:0] idx;
    } win_type;

    typedef struct packed {
        logic              awvalid;
        logic [AXI_AW-1:0] awaddr;
        logic              wvalid;
        logic [31:0]       wdata;
        logic [3:0]        wstrb;
        logic              bready;
        logic              arvalid;
        logic [AXI_AW-1:0] araddr;
        logic              rready;
    } axil_req_type;

    typedef struct packed {
        logic        awready;
        logic        wready;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        arready;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
    } axil_rsp_type;

endpackage

// ===== testbench/pcm_highway_model.sv
`timescale 1ns/10ps
// Highway master: on the bit clock it is given, frame sync once per frame, receive
// pattern driven on every bit (other talkers fill the unused slots)
module pcm_highway_model #(
    parameter int           F      = 128,
    parameter logic [F-1:0] RX_PAT = '0
) (
    input  wire logic         pclk,
    output logic              frame_sync_pulse,
    output logic              pcm_rx_in,
    input  wire logic         pcm_tx_out,
    input  wire logic         pcm_tx_oe,
    output logic [F-1:0]      oe_mid_r,
    output logic [F-1:0]      tx_mid_r,
    output logic [F-1:0]      oe_end_r,
    output logic [F-1:0]      tx_end_r
);
    int cur_r = 0;

    initial begin
        frame_sync_pulse = 1'b0;
        pcm_rx_in        = 1'b0;
    end

    // Capture at end of bit suits falling-edge launch
    always @(posedge pclk) begin
        oe_end_r[cur_r]  <= pcm_tx_oe;
        tx_end_r[cur_r]  <= pcm_tx_out;
        cur_r            <= (cur_r == F - 1) ? 0 : cur_r + 1;
        frame_sync_pulse <= (cur_r == F - 2);
        pcm_rx_in        <= RX_PAT[F - 1 - ((cur_r + 1) % F)];
    end

    // Capture mid-bit suits rising-edge launch
    always @(negedge pclk) begin
        oe_mid_r[cur_r] <= pcm_tx_oe;
        tx_mid_r[cur_r] <= pcm_tx_out;
    end
endmodule // pcm_highway_model

// ===== testbench/test_pcm_highway_time_slot_port.sv
`timescale 1ns/10ps
`define CHK(nm, e, g) begin \
    n_tests++; \
    if ((g) !== (e)) begin \
        num_errors++; \
        $display("ERROR %s expected %h seen %h", nm, e, g); \
    end \
end
module test_pcm_highway_time_slot_port;
    import pcm_port_pkg::*;
    // Short frame keeps the run brief; equal to the 128-bit minimum
    localparam int           F      = 128;
    localparam int           LIMIT  = 4000;
    localparam logic [F-1:0] RX_PAT = 128'hF00F_1234_5678_9ABC_DEF0_0FF0_A55A_C33C;
    typedef struct packed {
        cfg_type     c;
        logic [31:0] txd;
    } row_type;
    localparam row_type ROWS [6] = '{
        '{'{1'h1, 1'h0, 1'h0, 1'h0, 3'h0, 3'h0, 7'h00, 7'h03}, 32'h000000A5},
        '{'{1'h1, 1'h0, 1'h0, 1'h1, 3'h7, 3'h0, 7'h0E, 7'h0F}, 32'h0000003C},
        '{'{1'h1, 1'h0, 1'h1, 1'h0, 3'h3, 3'h7, 7'h02, 7'h05}, 32'h00001234},
        '{'{1'h1, 1'h1, 1'h1, 1'h1, 3'h0, 3'h1, 7'h01, 7'h04}, 32'hBEEF5A5A},
        '{'{1'h1, 1'h1, 1'h0, 1'h0, 3'h7, 3'h0, 7'h06, 7'h00}, 32'h00C30081},
        '{'{1'h0, 1'h0, 1'h0, 1'h0, 3'h0, 3'h0, 7'h03, 7'h03}, 32'h0000FFFF}
    };

    logic          aclk = 1'b0;
    logic          aresetn = 1'b0;
    logic          pclk = 1'b0;
    axil_req_type  rq;
    axil_rsp_type  rs;
    logic          fs;
    logic          rx;
    logic          tx;
    logic          oe;
    logic [F-1:0]  oe_mid;
    logic [F-1:0]  tx_mid;
    logic [F-1:0]  oe_end;
    logic [F-1:0]  tx_end;
    logic [31:0]   d;
    logic [1:0]    rsp;
    int            num_errors = 0;
    int            n_tests = 0;
    int            cycles = 0;

    always #50 aclk = ~aclk;
    initial begin
        #3.3;
        forever #6 pclk = ~pclk;
    end

    pcm_port dut_u (
        .aclk             (aclk),
        .aresetn          (aresetn),
        .axil_req         (rq),
        .axil_rsp         (rs),
        .pclk             (pclk),
        .frame_sync_pulse (fs),
        .pcm_rx_in        (rx),
        .pcm_tx_out       (tx),
        .pcm_tx_oe        (oe)
    );

    pcm_highway_model #(.F(F), .RX_PAT(RX_PAT)) pm_u (
        .pclk             (pclk),
        .frame_sync_pulse (fs),
        .pcm_rx_in        (rx),
        .pcm_tx_out       (tx),
        .pcm_tx_oe        (oe),
        .oe_mid_r         (oe_mid),
        .tx_mid_r         (tx_mid),
        .oe_end_r         (oe_end),
        .tx_end_r         (tx_end)
    );

    task automatic wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] r);
        logic aw_done;
        logic w_done;
        @(posedge aclk);
        rq.awvalid <= 1'b1;
        rq.awaddr  <= a;
        rq.wvalid  <= 1'b1;
        rq.wdata   <= v;
        rq.bready  <= 1'b1;
        aw_done = 1'b0;
        w_done  = 1'b0;
        while (!(aw_done && w_done)) begin
            @(posedge aclk);
            aw_done = aw_done | (rs.awready === 1'b1);
            w_done  = w_done | (rs.wready === 1'b1);
            if (aw_done) rq.awvalid <= 1'b0;
            if (w_done) rq.wvalid <= 1'b0;
        end
        while (rs.bvalid !== 1'b1) @(posedge aclk);
        r = rs.bresp;
        rq.bready <= 1'b0;
        // Configuration crosses by toggle; give it time to land
        repeat (6) @(posedge aclk);
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] r);
        @(posedge aclk);
        rq.arvalid <= 1'b1;
        rq.araddr  <= a;
        rq.rready  <= 1'b1;
        do @(posedge aclk); while (rs.arready !== 1'b1);
        rq.arvalid <= 1'b0;
        while (rs.rvalid !== 1'b1) @(posedge aclk);
        v = rs.rdata;
        r = rs.rresp;
        rq.rready <= 1'b0;
    endtask

    function automatic logic [31:0] exp_rx(input cfg_type c);
        logic [31:0] v;
        int          s;
        int          l;
        v = 32'h0;
        s = c.rx_ts * 8 + c.rx_cs;
        l = c.linear ? 16 : 8;
        for (int k = 0; k < l; k++) begin
            v[l - 1 - k] = RX_PAT[F - 1 - s - k];
            if (c.wide) v[16 + l - 1 - k] = RX_PAT[F - 1 - s - F / 2 - k];
        end
        return v;
    endfunction

    task automatic run_row(input row_type w);
        int   s;
        int   l;
        int   k;
        logic hi;
        logic eo;
        logic ed;
        wr(CTRL_OFS, 32'h0, rsp);
        wr(SLOT_OFS, {17'h0, w.c.rx_ts, 1'b0, w.c.tx_ts}, rsp);
        wr(TXD_OFS, w.txd, rsp);
        wr(CTRL_OFS, {21'h0, w.c.rx_cs, 1'b0, w.c.tx_cs, w.c.tx_fall, w.c.linear,
                      w.c.wide, w.c.enable}, rsp);
        repeat (80) @(posedge aclk);
        s = w.c.tx_ts * 8 + w.c.tx_cs;
        l = w.c.linear ? 16 : 8;
        for (int n = 0; n < F; n++) begin
            hi = w.c.wide && (n >= s + F / 2);
            k  = hi ? n - s - F / 2 : n - s;
            eo = w.c.enable && (k >= 0) && (k < l);
            `CHK("tx_oe", eo, w.c.tx_fall ? oe_end[n] : oe_mid[n])
            if (eo) begin
                ed = hi ? w.txd[16 + l - 1 - k] : w.txd[l - 1 - k];
                `CHK("tx_bit", ed, w.c.tx_fall ? tx_end[n] : tx_mid[n])
            end
        end
        if (w.c.enable) begin
            rd(RXD_OFS, d, rsp);
            if (!w.c.wide) d[31:16] = 16'h0;
            `CHK("rxd", exp_rx(w.c), d)
        end
    endtask

    task automatic wrap_up;
        $display("Comparisons %0d, mismatches %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    always @(posedge aclk) begin
        cycles++;
        if (cycles == LIMIT) begin
            num_errors++;
            wrap_up();
        end
    end

    initial begin
        rq = '0;
        rq.wstrb = 4'hF;
        repeat (5) @(posedge aclk);
        `CHK("oe_rst", 1'b0, oe)
        aresetn <= 1'b1;
        rd(CTRL_OFS, d, rsp);
        `CHK("ctrl_rst", CTRL_RST, d)
        rd(SLOT_OFS, d, rsp);
        `CHK("slot_rst", SLOT_RST, d)
        for (int i = 0; i < 6; i++) run_row(ROWS[i]);
        // Port now disabled, link still running; reading the data clears rx_new, overrun stays
        rd(RXD_OFS, d, rsp);
        rd(STAT_OFS, d, rsp);
        `CHK("stat", 3'b110, d[2:0])
        wr(STAT_OFS, 32'h2, rsp);
        rd(STAT_OFS, d, rsp);
        `CHK("stat_clr", 3'b100, d[2:0])
        wr(RXD_OFS, 32'hFFFFFFFF, rsp);
        `CHK("rxd_wr", RESP_OKAY, rsp)
        wr(8'h20, 32'h1, rsp);
        `CHK("bad_wr", RESP_SLVERR, rsp)
        rd(8'h20, d, rsp);
        `CHK("bad_rd", RESP_SLVERR, rsp)
        // Second reset in mid-run with the port enabled
        wr(CTRL_OFS, 32'h1, rsp);
        aresetn <= 1'b0;
        repeat (5) @(posedge aclk);
        `CHK("oe_rst2", 1'b0, oe)
        aresetn <= 1'b1;
        rd(CTRL_OFS, d, rsp);
        `CHK("ctrl_rst2", CTRL_RST, d)
        rd(STAT_OFS, d, rsp);
        `CHK("stat_rst2", 2'b00, d[1:0])
        wrap_up();
    end
endmodule // test_pcm_highway_time_slot_port
